//--- rtl/hcc_pkg.sv
// Constants shared by the host channel control block.
// Assumes an 8-bit register port addressed by the printed offsets.
package hcc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port
    localparam int          HCC_ADDR_W   = 10;
    localparam int          HCC_DATA_W   = 8;
    localparam logic [9:0]  OFS_CTL_RES  = 10'h18E;
    localparam logic [9:0]  OFS_CFG_A    = 10'h190;
    localparam logic [9:0]  OFS_CFG_B    = 10'h191;
    localparam logic [7:0]  RST_CTL_RES  = 8'h00;
    localparam logic [7:0]  RST_CFG_A    = 8'h00;
    localparam logic [7:0]  RST_CFG_B    = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int RES_LSB  = 4;
    localparam int ACK_LSB  = 4;
    localparam int SPD_LSB  = 2;
    localparam int TGL_BIT  = 1;
    localparam int GO_BIT   = 0;
    localparam int TID_LSB  = 6;
    localparam int ZLP_BIT  = 3;
    localparam int FREE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Completion result codes
    localparam logic [2:0] RC_OK    = 3'h0;
    localparam logic [2:0] RC_STALL = 3'h1;
    localparam logic [2:0] RC_OVER  = 3'h2;
    localparam logic [2:0] RC_UNDER = 3'h3;
    localparam logic [2:0] RC_RETRY = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Token direction and ACK target
    localparam logic [1:0] TID_OUT  = 2'h1;
    localparam logic [1:0] TID_IN   = 2'h2;
    localparam logic [4:0] ACK_FULL = 5'h10;

    typedef enum logic [1:0] {
        S_IDLE,
        S_ISSUE,
        S_WAIT
    } hcc_state_t;

endpackage

//--- rtl/hcc_res_enc.sv
// Completion result encoder for one finished transaction.
// Assumes the error flags are valid in the cycle of the end pulse.
`timescale 1ns/1ps
`default_nettype none
module hcc_res_enc
    import hcc_pkg::*;
(
    input  wire logic       stall,       // Stall handshake seen
    input  wire logic       over_max,    // Packet above max packet size
    input  wire logic       over_total,  // Bytes above programmed total
    input  wire logic       short_pkt,   // Packet below max packet size
    input  wire logic       under_total, // Received total below programmed
    input  wire logic       crc_err,     // CRC error
    input  wire logic       stuff_err,   // Bit stuffing error
    input  wire logic       timeout,     // No response or handshake
    input  wire logic       pid_chk,     // PID check bits failed
    input  wire logic       pid_bad,     // Invalid or undefined PID
    input  wire logic       toggle_err,  // Data toggle mismatch
    output logic [2:0]      code         // Encoded result
);

    function automatic logic [2:0] encode(
        input logic st, input logic om, input logic ot, input logic sp,
        input logic ut, input logic ce, input logic se, input logic to,
        input logic pc, input logic pb, input logic te);
        logic retry;
        retry = to | ce | se | pc | pb | te;
        if (st)
            return RC_STALL;
        if (ce && se)
            return RC_RETRY;
        if (sp && te)
            return RC_RETRY;
        if (om || ot)
            return RC_OVER;
        if (sp && ut)
            return RC_UNDER;
        if (retry)
            return RC_RETRY;
        return RC_OK;
    endfunction

    always_comb begin
        code = encode(stall, over_max, over_total, short_pkt, under_total,
                      crc_err, stuff_err, timeout, pid_chk, pid_bad, toggle_err);
    end

endmodule
`default_nettype wire

//--- rtl/hcc_chan_ctrl.sv
// Host channel control: control channel result code and bulk channel a
// configuration, token sequencing, ACK counting and completion events.
// Assumes a packet engine on mclk that runs each token and reports one
// end pulse with flags, and a mass storage assist driving bo_* inputs.
// Functional notes
// - Control result code sits in bits 6..4, read only; 000 is success.
// - Stall handshake gives code 001.
// - Packet over max size or bytes over total give code 010.
// - Over or underrun with CRC and stuffing errors becomes retry error.
// - Short packet with toggle mismatch is a toggle mismatch, not overrun.
// - Short packet with total below programmed gives code 011.
// - Timeout, CRC, stuffing, PID faults or toggle mismatch give code 100.
// - Under mass storage assist only data transport ACKs are counted.
// - Written toggle seeds the transaction; reads show the live toggle.
// - Launch bit 1 starts, 0 stops; reads show running state.
// - Full byte total done raises done event and clears launch.
// - Halt on transfer problem clears launch and records the cause.
// - Software stop halts after the current transaction; resume keeps state.
// - Direction 01 issues OUT tokens, 10 issues IN tokens.
// - Direction field ignored while mass storage assist runs.
// - OUT with auto option appends zero length packet on exact boundary.
// - Unbounded length ignores the programmed byte total.
// - Control assist abort on packet error records its cause.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module hcc_chan_ctrl
    import hcc_pkg::*;
#(
    parameter int MPS_W   = 10,
    parameter int BYTES_W = 11,
    parameter int TOTAL_W = 32
)(
    input  wire logic                  mclk,           // 250 MHz clock
    input  wire logic                  rst_b,          // Async reset, low
    input  wire logic [HCC_ADDR_W-1:0] reg_addr,       // Register address
    input  wire logic [HCC_DATA_W-1:0] reg_wdata,      // Write data
    input  wire logic                  reg_wr,         // Write strobe
    input  wire logic                  reg_rd,         // Read strobe
    output logic      [HCC_DATA_W-1:0] reg_rdata,      // Read data, next cycle
    input  wire logic                  ctl_txn_end,    // Control txn ended
    input  wire logic                  ctrl_assist_abort, // Control assist error stop
    input  wire logic                  bulk_txn_end,   // Bulk txn ended
    input  wire logic                  res_stall,      // Stall seen
    input  wire logic                  res_over_max,   // Above max packet
    input  wire logic                  res_over_total, // Above total
    input  wire logic                  res_short,      // Short packet
    input  wire logic                  res_under_total,// Below total
    input  wire logic                  res_crc,        // CRC error
    input  wire logic                  res_stuff,      // Stuffing error
    input  wire logic                  res_timeout,    // Response timeout
    input  wire logic                  res_pid_chk,    // PID check failed
    input  wire logic                  res_pid_bad,    // Invalid PID
    input  wire logic                  res_toggle,     // Toggle mismatch
    input  wire logic [BYTES_W-1:0]    txn_bytes,      // Bytes in ended txn
    input  wire logic [MPS_W-1:0]      max_pkt_size,   // Bulk max packet size
    input  wire logic [TOTAL_W-1:0]    byte_total,     // Programmed total
    input  wire logic                  chan_reload,    // Load total, new xfer
    input  wire logic                  bo_active,      // Assist running
    input  wire logic                  bo_launch,      // Assist start pulse
    input  wire logic                  bo_dir_in,      // Assist direction IN
    input  wire logic                  bo_data_phase,  // Assist data transport
    output logic                       tok_req,        // Token request pulse
    output logic                       tok_in,         // 1 IN, 0 OUT
    output logic                       tok_toggle,     // Data toggle for token
    output logic [1:0]                 tok_speed,      // Speed selection
    output logic                       tok_zlp,        // Zero length packet
    output logic                       ack_target_reached, // Pulse
    output logic                       byte_total_done,    // Pulse
    output logic                       channel_halted_event, // Pulse
    output logic [2:0]                 bulk_result_code    // Bulk result
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    hcc_state_t         state_q;
    logic [3:0]         ack_tgt_q;
    logic [1:0]         speed_select_q;
    logic               toggle_q;
    logic               launch_q;
    logic [1:0]         token_direction_q;
    logic               auto_zlp_append_q;
    logic               unbounded_length_q;
    logic [TOTAL_W-1:0] remaining_q;
    logic [4:0]         ack_cnt_q;
    logic [2:0]         ctl_res_q;
    logic [2:0]         bulk_res_q;
    logic [7:0]         rdata_q;
    logic               tok_req_q;
    logic               tok_in_q;
    logic               tok_toggle_q;
    logic               tok_zlp_q;
    logic               ack_evt_q;
    logic               done_evt_q;
    logic               halt_evt_q;
    logic [2:0]         code;
    logic               wr_a;
    logic               wr_b;
    logic               done;
    logic               err;
    logic               dir_in;
    logic               dir_ok;
    logic               full_pkt;
    logic [TOTAL_W-1:0] rem_d;
    logic               at_end;
    logic               zlp_need;
    logic               finish;
    logic               halt;
    logic               ack_evt;
    logic [4:0]         ack_tgt;
    logic [4:0]         ack_cnt_d;

    function automatic logic [TOTAL_W-1:0] sat_sub(
        input logic [TOTAL_W-1:0] a, input logic [BYTES_W-1:0] b);
        logic [TOTAL_W-1:0] bw;
        bw = TOTAL_W'(b);
        return (a > bw) ? a - bw : '0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Result encoding, shared by both channels
    hcc_res_enc u_enc (
        .stall       (res_stall),
        .over_max    (res_over_max),
        .over_total  (res_over_total),
        .short_pkt   (res_short),
        .under_total (res_under_total),
        .crc_err     (res_crc),
        .stuff_err   (res_stuff),
        .timeout     (res_timeout),
        .pid_chk     (res_pid_chk),
        .pid_bad     (res_pid_bad),
        .toggle_err  (res_toggle),
        .code        (code)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bulk sequencing terms
    always_comb begin
        wr_a     = reg_wr && (reg_addr == OFS_CFG_A);
        wr_b     = reg_wr && (reg_addr == OFS_CFG_B);
        done     = bulk_txn_end && (state_q == S_WAIT);
        err      = (code != RC_OK);
        dir_in   = bo_active ? bo_dir_in : (token_direction_q == TID_IN);
        // only 01 and 10 may launch unless the assist runs, which allows any value
        dir_ok   = bo_active || (token_direction_q == TID_OUT) || (token_direction_q == TID_IN);
        full_pkt = (txn_bytes == BYTES_W'(max_pkt_size));
        rem_d    = sat_sub(remaining_q, txn_bytes);
        at_end   = !unbounded_length_q && (rem_d == '0);
        zlp_need = at_end && !dir_in && auto_zlp_append_q && full_pkt && !tok_zlp_q;
        finish   = done && !err && at_end && !zlp_need;
        halt     = done && (err || (!launch_q && !finish && !zlp_need));
        ack_evt  = done && !err && (!bo_active || bo_data_phase);
        ack_tgt  = (ack_tgt_q == 4'h0) ? ACK_FULL : {1'b0, ack_tgt_q};
        ack_cnt_d = ack_cnt_q + 5'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack_tgt_q          <= RST_CFG_A[ACK_LSB +: 4];
            speed_select_q     <= RST_CFG_A[SPD_LSB +: 2];
            token_direction_q  <= RST_CFG_B[TID_LSB +: 2];
            auto_zlp_append_q  <= RST_CFG_B[ZLP_BIT];
            unbounded_length_q <= RST_CFG_B[FREE_BIT];
        end else begin
            if (wr_a) begin
                ack_tgt_q      <= reg_wdata[ACK_LSB +: 4];
                speed_select_q <= reg_wdata[SPD_LSB +: 2];
            end
            if (wr_b) begin
                token_direction_q  <= reg_wdata[TID_LSB +: 2];
                auto_zlp_append_q  <= reg_wdata[ZLP_BIT];
                unbounded_length_q <= reg_wdata[FREE_BIT];
            end
        end
    end

    // seed by write, flip on good txn
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            toggle_q <= RST_CFG_A[TGL_BIT];
        else if (done && !err)
            toggle_q <= !toggle_q;
        else if (wr_a)
            toggle_q <= reg_wdata[TGL_BIT];
    end

    // software write wins over hardware clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            launch_q <= RST_CFG_A[GO_BIT];
        else if (wr_a)
            launch_q <= reg_wdata[GO_BIT];
        else if (bo_launch)
            launch_q <= 1'b1;
        else if (finish || halt)
            launch_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Token sequencer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q      <= S_IDLE;
            tok_req_q    <= 1'b0;
            tok_in_q     <= 1'b0;
            tok_toggle_q <= 1'b0;
            tok_zlp_q    <= 1'b0;
        end else begin
            tok_req_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    tok_zlp_q <= 1'b0;
                    if (launch_q && dir_ok)
                        state_q <= S_ISSUE;
                end
                S_ISSUE: begin
                    tok_req_q    <= 1'b1;
                    tok_in_q     <= dir_in;
                    tok_toggle_q <= toggle_q;
                    state_q      <= S_WAIT;
                end
                S_WAIT: begin
                    if (done) begin
                        // stop takes effect after the txn
                        if (halt || finish) begin
                            state_q <= S_IDLE;
                        end else begin
                            tok_zlp_q <= zlp_need;
                            state_q   <= S_ISSUE;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // remaining total kept across a stop
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            remaining_q <= '0;
        else if (done)
            remaining_q <= rem_d;
        else if (chan_reload)
            remaining_q <= byte_total;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack_cnt_q <= 5'h00;
            ack_evt_q <= 1'b0;
        end else begin
            ack_evt_q <= 1'b0;
            if (ack_evt) begin
                if (ack_cnt_d >= ack_tgt) begin
                    ack_cnt_q <= 5'h00;
                    ack_evt_q <= 1'b1;
                end else begin
                    ack_cnt_q <= ack_cnt_d;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and result codes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done_evt_q <= 1'b0;
            halt_evt_q <= 1'b0;
        end else begin
            done_evt_q <= finish;
            halt_evt_q <= halt;
        end
    end

    // codes change only at an end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_res_q  <= RST_CTL_RES[RES_LSB +: 3];
            bulk_res_q <= RC_OK;
        end else begin
            if (ctl_txn_end || ctrl_assist_abort)
                ctl_res_q <= code;
            if (done)
                bulk_res_q <= code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_CTL_RES: rdata_q <= {1'b0, ctl_res_q, 4'h0};
                OFS_CFG_A:   rdata_q <= {ack_tgt_q, speed_select_q, toggle_q, launch_q};
                OFS_CFG_B:   rdata_q <= {token_direction_q, 2'h0, auto_zlp_append_q,
                                         2'h0, unbounded_length_q};
                default:     rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    always_comb begin
        reg_rdata            = rdata_q;
        tok_req              = tok_req_q;
        tok_in               = tok_in_q;
        tok_toggle           = tok_toggle_q;
        tok_speed            = speed_select_q;
        tok_zlp              = tok_zlp_q;
        ack_target_reached   = ack_evt_q;
        byte_total_done      = done_evt_q;
        channel_halted_event = halt_evt_q;
        bulk_result_code     = bulk_res_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_token;
        state_q == S_ISSUE ##1 tok_req_q;
    endsequence

    sequence s_zlp_token;
        state_q == S_ISSUE ##1 (tok_req_q && tok_zlp_q);
    endsequence

    a_stall_code: assert property (@(posedge mclk) disable iff (!rst_b)
        ctl_txn_end && res_stall |=> ctl_res_q == RC_STALL)
        else $error("stall not reported as 001");

    a_retry_prio: assert property (@(posedge mclk) disable iff (!rst_b)
        (ctl_txn_end || ctrl_assist_abort) && !res_stall && res_crc && res_stuff && res_over_max
        |=> ctl_res_q == RC_RETRY)
        else $error("CRC plus stuffing did not give retry");

    a_short_toggle: assert property (@(posedge mclk) disable iff (!rst_b)
        ctl_txn_end && !res_stall && res_short && res_toggle |=> ctl_res_q == RC_RETRY)
        else $error("short toggle mismatch not retry");

    a_code_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !ctl_txn_end && !ctrl_assist_abort |=> $stable(ctl_res_q))
        else $error("control result changed without an end");

    a_done_clears: assert property (@(posedge mclk) disable iff (!rst_b)
        finish && !wr_a && !bo_launch |=> byte_total_done && !launch_q && state_q == S_IDLE)
        else $error("total done did not clear launch");

    a_halt_cause: assert property (@(posedge mclk) disable iff (!rst_b)
        done && err && !wr_a && !bo_launch |=> channel_halted_event && !launch_q
                                            && bulk_result_code != RC_OK)
        else $error("halt did not record cause");

    a_token_dir: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == S_ISSUE && !bo_active && token_direction_q == TID_IN |-> s_token ##0 tok_in_q)
        else $error("IN direction did not issue IN token");

    a_zlp_append: assert property (@(posedge mclk) disable iff (!rst_b)
        done && !err && zlp_need |=> s_zlp_token)
        else $error("zero length packet not appended");

    a_ack_target: assert property (@(posedge mclk) disable iff (!rst_b)
        ack_target_reached |-> $past(ack_cnt_q) + 5'h01 == $past(ack_tgt))
        else $error("ACK target flagged at wrong count");

    a_stop_resume: assert property (@(posedge mclk) disable iff (!rst_b)
        done && !err && !launch_q && !at_end |=> channel_halted_event && remaining_q == $past(rem_d))
        else $error("software stop lost position");

endmodule
`default_nettype wire

//--- dv/hcc_usb_peer.sv
// Peripheral model: answers each bulk token once, after a set delay.
// Assumes tokens arrive one at a time from the channel control.
`timescale 1ns/1ps
`default_nettype none
module hcc_usb_peer (
    input  wire logic        mclk,    // Clock
    input  wire logic        rst_b,   // Reset, low
    input  wire logic        tok_req, // Token pulse
    input  wire logic        tok_zlp, // Zero length token
    input  wire logic [2:0]  dly,     // Answer delay
    input  wire logic [10:0] pkt,     // Packet bytes
    output logic             t_end,   // Txn end pulse
    output logic [10:0]      t_bytes  // Bytes moved, valid with t_end
);
    logic [3:0] cnt_q;
    logic       zlp_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {cnt_q, zlp_q, t_end, t_bytes} <= '0;
        end else begin
            t_end <= 1'b0;
            t_bytes <= ~t_bytes;
            if (tok_req) begin
                {cnt_q, zlp_q} <= {{1'b0, dly} + 4'h1, tok_zlp};
            end else if (cnt_q == 4'h1) begin
                cnt_q <= 4'h0;
                t_end <= 1'b1;
                // Zero length token moves no bytes
                t_bytes <= zlp_q ? 11'h000 : pkt;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Bench: registers, result codes and bulk transfers of the channel control.
// Assumes the peripheral model answers tokens; result flags are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hcc_pkg::*;
;
    logic mclk, rst_b, reg_wr, reg_rd, ctl_txn_end, ctrl_assist_abort, chan_reload, bulk_txn_end;
    logic bo_active, bo_launch, bo_dir_in, bo_data_phase, res_stall, res_over_max, res_over_total;
    logic res_short, res_under_total, res_crc, res_stuff, res_timeout, res_pid_chk, res_pid_bad, res_toggle;
    logic tok_req, tok_in, tok_toggle, tok_zlp, ack_target_reached, byte_total_done, channel_halted_event;
    logic [1:0]  tok_speed;
    logic [2:0]  bulk_result_code, dly;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [9:0]  reg_addr, max_pkt_size;
    logic [10:0] f, v, txn_bytes, pkt;
    logic [31:0] byte_total;
    logic [10:0] corner[4] = '{11'h230, 11'h281, 11'h0C0, 11'h4FF};
    int          n_mismatch, checked, cyc, n, ev[6], seed = 32'hE4EFA7E9;
    logic        spd;
    assign {res_stall, res_over_max, res_over_total, res_short, res_under_total, res_crc, res_stuff,
            res_timeout, res_pid_chk, res_pid_bad, res_toggle} = f;
    hcc_chan_ctrl DUT (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ctl_txn_end,
        .ctrl_assist_abort, .bulk_txn_end, .res_stall, .res_over_max, .res_over_total, .res_short,
        .res_under_total, .res_crc, .res_stuff, .res_timeout, .res_pid_chk, .res_pid_bad, .res_toggle,
        .txn_bytes, .max_pkt_size, .byte_total, .chan_reload, .bo_active, .bo_launch, .bo_dir_in,
        .bo_data_phase, .tok_req, .tok_in, .tok_toggle, .tok_speed, .tok_zlp, .ack_target_reached,
        .byte_total_done, .channel_halted_event, .bulk_result_code);
    hcc_usb_peer peer (.mclk, .rst_b, .tok_req, .tok_zlp, .dly, .pkt, .t_end(bulk_txn_end), .t_bytes(txn_bytes));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Event counters: tokens, zero length tokens, done, halt, ack, IN tokens
    always @(posedge mclk) begin
        {ev[0], ev[1], ev[2]} = {ev[0] + tok_req, ev[1] + (tok_req & tok_zlp), ev[2] + byte_total_done};
        {ev[3], ev[4], ev[5]} = {ev[3] + channel_halted_event, ev[4] + ack_target_reached, ev[5] + (tok_req & tok_in)};
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic go(input logic [7:0] cb, input logic [31:0] t, input logic [7:0] ca);
        wr(OFS_CFG_B, cb);
        {byte_total, chan_reload, dly} <= {t, 1'b1, 3'($random(seed)) | 3'h1};
        @(posedge mclk);
        chan_reload <= 1'b0;
        #1 ev = '{default: 0};
        wr(OFS_CFG_A, ca);
    endtask
    task automatic wait_end(input int k);
        for (int i = 0; i < 600 && ev[2] + ev[3] < k; i++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        #1;
        if (ev[2] + ev[3] < k) begin
            n_mismatch++;
            $display("mismatch at %0t: transfer did not end", $time);
        end
    endtask
    function automatic logic [2:0] rc(input logic [10:0] x);
        if (x[10]) return RC_STALL;
        if ((x[5] && x[4]) || (x[7] && x[0])) return RC_RETRY;
        if (x[9] || x[8]) return RC_OVER;
        if (x[7] && x[6]) return RC_UNDER;
        return (|x[5:0]) ? RC_RETRY : RC_OK;
    endfunction
    task automatic finish_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reg_wr, reg_rd, ctl_txn_end, ctrl_assist_abort, chan_reload, bo_active, bo_launch} = '0;
        {bo_dir_in, bo_data_phase, rst_b, f, reg_addr, reg_wdata, byte_total, dly} = '0;
        {max_pkt_size, pkt} = {10'h040, 11'h040};
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        rd(OFS_CTL_RES, RST_CTL_RES);
        rd(OFS_CFG_A, RST_CFG_A);
        rd(OFS_CFG_B, RST_CFG_B);
        wr(OFS_CTL_RES, 8'hFF);
        rd(OFS_CTL_RES, 8'h00);
        wr(OFS_CFG_B, 8'hFF);
        rd(OFS_CFG_B, 8'hC9);
        rd(10'h1FF, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            v = (i < 4) ? corner[i] : (i < 15) ? 11'h001 << (i - 4) : 11'($random(seed) & $random(seed));
            @(posedge mclk);
            {f, ctl_txn_end, ctrl_assist_abort} <= {v, i[0], ~i[0]};
            @(posedge mclk);
            {ctl_txn_end, ctrl_assist_abort} <= 2'b00;
            rd(OFS_CTL_RES, {1'b0, rc(v), 4'h0});
        end
        rd(OFS_CTL_RES, {1'b0, rc(v), 4'h0});
        $display("test result codes done");
        f <= '0;
        spd = 1'($random(seed));
        go(8'h48, 32'd128, {4'h3, 1'b0, spd, 2'b01});
        wait_end(1);
        chk(8'(ev[0]), 8'd3);
        chk(8'(ev[1]), 8'd1);
        chk(8'(ev[2]), 8'd1);
        chk(8'(ev[4] + ev[5]), 8'd1);
        chk({6'h0, tok_speed}, {7'h0, spd});
        rd(OFS_CFG_A, {4'h3, 1'b0, spd, 2'b10});
        f <= 11'h020;
        go(8'h80, 32'd64, 8'h11);
        wait_end(1);
        chk(8'(ev[3] + ev[4]), 8'd1);
        chk({5'h0, bulk_result_code}, {5'h0, RC_RETRY});
        chk(8'(ev[5]), 8'(ev[0]));
        rd(OFS_CFG_A, 8'h10);
        $display("test bulk done");
        f <= '0;
        {bo_active, bo_dir_in, bo_data_phase} <= 3'b110;
        go(8'h00, 32'd192, 8'h12);
        bo_launch <= 1'b1;
        @(posedge mclk);
        bo_launch <= 1'b0;
        wait_end(1);
        chk(8'(ev[5]), 8'd3);
        chk(8'(ev[4] + ev[2]), 8'd1);
        chk({7'h0, tok_toggle}, 8'h01);
        bo_active <= 1'b0;
        $display("test assist done");
        f <= '0;
        go(8'h41, 32'd0, 8'h01);
        for (int i = 0; i < 300 && ev[0] < 3; i++) @(posedge mclk);
        wr(OFS_CFG_A, 8'h00);
        wait_end(1);
        chk(8'(ev[3] + ev[2]), 8'd1);
        chk({5'h0, bulk_result_code}, {5'h0, RC_OK});
        rd(OFS_CFG_A, {6'h0, ev[0][0], 1'b0});
        n = ev[0];
        wr(OFS_CFG_A, 8'h01);
        repeat (20) @(posedge mclk);
        chk({7'h0, ev[0] > n}, 8'h01);
        wr(OFS_CFG_A, 8'h00);
        wait_end(2);
        $display("test stop done");
        finish_test();
    end
endmodule
`default_nettype wire
